// ==== rtl/stp_cfg.svh ====
// Shared constants of the stepper serial command port and its controller.
`ifndef STP_CFG_SVH
`define STP_CFG_SVH
// Overview of operation
// - Ports chain data-out to data-in into one register.
// - Host may give each device own select line.
// - Sixteen-bit frame: first four bits are dummies.
// - Frames under twelve clock bits are discarded.
// - Data out floats while enable or select high.
// - Polarity change restarts that phase's chopper.
// - Tripped comparator at period start keeps bridge off.
// - Polarity applied within chopper period plus 4us.
// - Load indicator valid 7us after polarity change.
// - Host waits 30us after enable before clocking.
// - Current code zero switches coil fully off.
// - Host puts inverted extension bits in upper four.

// ==========================================================================
// Clock and timing.
`define STP_CLK_NS          25
`define STP_CEIL(ns)        (((ns) + `STP_CLK_NS - 1) / `STP_CLK_NS)
`define STP_FLOOR(ns)       ((ns) / `STP_CLK_NS)
`define STP_SCK_PERIOD_NS   250
`define STP_SCK_HALF_CYC    `STP_CEIL(`STP_SCK_PERIOD_NS / 2)
`define STP_CS_GUARD_NS     50
`define STP_CS_GUARD_CYC    `STP_CEIL(`STP_CS_GUARD_NS)
`define STP_EN_SETUP_US     30
`define STP_EN_SETUP_CYC    `STP_CEIL(`STP_EN_SETUP_US * 1000)
`define STP_CHOP_US         40
`define STP_CHOP_CYC        `STP_FLOOR(`STP_CHOP_US * 1000)
`define STP_FAST_CYC        (`STP_CHOP_CYC / 4)
`define STP_POL_DELAY_US    4
`define STP_LOAD_VALID_US   7
`define STP_LOAD_VALID_CYC  `STP_CEIL(`STP_LOAD_VALID_US * 1000)
`define STP_LOAD_WAIT_CYC   `STP_CEIL((`STP_CHOP_US + `STP_POL_DELAY_US + `STP_LOAD_VALID_US) * 1000)

// ==========================================================================
// Frame layout.
`define STP_CMD_BITS        12
`define STP_FRAME_BITS      16
`define STP_WORD_BITS       32
`define STP_POL_A_BIT       6
`define STP_POL_B_BIT       0
`define STP_CMD_RST         12'h000
`define STP_DRIVE_POS       2'h2
`define STP_DRIVE_NEG       2'h1
`define STP_DRIVE_OFF       2'h0

// ==========================================================================
// Device input synchroniser bit positions and reset image.
`define STP_IN_SCK          0
`define STP_IN_SEL          1
`define STP_IN_SDI          2
`define STP_IN_ENN          3
`define STP_IN_SENSE_A      4
`define STP_IN_SENSE_B      5
`define STP_DEV_SYNC_RST    6'h0a

// ==========================================================================
// Controller register map (byte offsets) and fields.
`define STP_REG_CTRL        5'h00
`define STP_REG_TXDATA      5'h04
`define STP_REG_RXDATA      5'h08
`define STP_REG_STATUS      5'h0c
`define STP_REG_IRQ_STATUS  5'h10
`define STP_REG_IRQ_CLEAR   5'h14
`define STP_REG_IRQ_ENABLE  5'h18
`define STP_CTRL_EN_BIT     0
`define STP_CTRL_EXT_LSB    4
`define STP_CTRL_EXT_MSB    7
`define STP_CTRL_LEN_LSB    8
`define STP_CTRL_LEN_MSB    13
`define STP_CTRL_LEN_RST    6'h10
`define STP_IRQ_DONE        0
`define STP_IRQ_READY       1
`endif

// ==== rtl/stp_pkg.sv ====
// Types shared by both ends of the stepper serial command port.
package stp_pkg;
  // ========================================================================
  // Twelve command bits, first shifted bit at the top.
  typedef struct packed {
    logic       phase_a_mixed_decay;
    logic [3:0] phase_a_current;
    logic       phase_a_polarity;
    logic       phase_b_mixed_decay;
    logic [3:0] phase_b_current;
    logic       phase_b_polarity;
  } stp_cmd_t;

  // ========================================================================
  // Controller frame sequencer states.
  typedef enum logic [5:0] {
    STP_H_IDLE  = 6'h01,
    STP_H_LEAD  = 6'h02,
    STP_H_LOW   = 6'h04,
    STP_H_HIGH  = 6'h08,
    STP_H_TRAIL = 6'h10,
    STP_H_GAP   = 6'h20
  } stp_host_state_t;
endpackage : stp_pkg

// ==== rtl/stp_link_if.sv ====
// Serial link between the controller and the driver's command port.
`timescale 1ns/1ps
interface stp_link_if;
  // ========================================================================
  // Link wires.
  logic sck;                // Serial clock, idles low.
  logic select_low;         // Frame select, active low.
  logic sdi;                // Data towards the driver.
  logic driver_enable_low;  // Bridge enable, active low.
  logic sdo;                // Driver data out, before the pad.
  logic sdo_oe;             // High while the driver drives its data out.
  logic sdo_line;           // Resolved level; a pull-up holds it high.

  // The floating pad is modelled by its pull-up level.
  assign sdo_line = sdo_oe ? sdo : 1'h1;

  modport host (
    output sck, select_low, sdi, driver_enable_low,
    input  sdo_line
  );
  modport dev (
    input  sck, select_low, sdi, driver_enable_low,
    output sdo, sdo_oe
  );
endinterface : stp_link_if

// ==== rtl/stp_device.sv ====
// Driver end: serial command port, chopper and bridge control.
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "stp_cfg.svh"
module stp_device #(
  parameter int CHOP_CYC = `STP_CHOP_CYC,       // Chopper period.
  parameter int FAST_CYC = `STP_FAST_CYC,       // Mixed decay fast part.
  parameter int LOAD_CYC = `STP_LOAD_VALID_CYC  // Load indicator settle.
) (
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // Serial link.
  stp_link_if.dev          link,
  // Current comparators, high when the trip level is exceeded.
  input  wire logic        phase_a_sense_input_i,
  input  wire logic        phase_b_sense_input_i,
  // Diagnostic word returned in each frame sent while the bridges are enabled.
  input  wire logic [11:0] diag_i,
  // Bridge drive and current codes.
  output logic      [1:0]  bridge_a_outputs_o,
  output logic      [1:0]  bridge_b_outputs_o,
  output logic      [3:0]  phase_a_current_o,
  output logic      [3:0]  phase_b_current_o,
  output logic             load_valid_o
);
  localparam int CW = $clog2(CHOP_CYC);
  localparam int FW = $clog2(FAST_CYC + 1);
  localparam int LW = $clog2(LOAD_CYC + 1);

  // ========================================================================
  // Input synchronisers.
  logic [5:0] raw;         // Pin levels as they arrive.
  logic [5:0] s1;          // First stage, read only by the second.
  logic [5:0] s2;          // Second stage.
  logic [5:0] s3;          // Third stage.
  logic [5:0] filt;        // Accepted levels.
  logic [5:0] filt_d;      // Accepted levels one cycle ago.
  logic [5:0] next_s1;
  logic [5:0] next_s2;
  logic [5:0] next_s3;
  logic [5:0] next_filt;

  assign raw = {phase_b_sense_input_i, phase_a_sense_input_i,
                link.driver_enable_low, link.sdi, link.select_low,
                link.sck};

  // A level counts only once the second and third stages agree, which
  // rejects one-cycle glitches on the slow link pins.
  always_comb begin
    next_s1   = raw;
    next_s2   = s1;
    next_s3   = s2;
    next_filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
  end

  // Synchroniser registers; the link idles deselected and disabled.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      s1     <= `STP_DEV_SYNC_RST;
      s2     <= `STP_DEV_SYNC_RST;
      s3     <= `STP_DEV_SYNC_RST;
      filt   <= `STP_DEV_SYNC_RST;
      filt_d <= `STP_DEV_SYNC_RST;
    end else begin
      s1     <= next_s1;
      s2     <= next_s2;
      s3     <= next_s3;
      filt   <= next_filt;
      filt_d <= filt;
    end
  end

  // Edges of the accepted link levels.
  logic sck_rise;   // Serial clock rising.
  logic sel_fall;   // Frame start.
  logic sel_rise;   // Frame end.
  assign sck_rise = filt[`STP_IN_SCK] & ~filt_d[`STP_IN_SCK];
  assign sel_fall = ~filt[`STP_IN_SEL] & filt_d[`STP_IN_SEL];
  assign sel_rise = filt[`STP_IN_SEL] & ~filt_d[`STP_IN_SEL];

  // ========================================================================
  // Command shift register.
  logic [11:0]      shreg;       // Last bits shifted in.
  logic [3:0]       bit_cnt;     // Bits seen, saturating at a command.
  stp_pkg::stp_cmd_t cmd;        // Active settings.
  logic [11:0]      next_shreg;
  logic [3:0]       next_bit_cnt;
  stp_pkg::stp_cmd_t next_cmd;

  // The register is loaded with the diagnostic word at frame start and
  // shifts once per serial clock, so its top bit feeds the next device.
  always_comb begin
    next_shreg   = shreg;
    next_bit_cnt = bit_cnt;
    next_cmd     = cmd;
    if (sel_fall) begin
      next_shreg   = diag_i;
      next_bit_cnt = 4'h0;
    end else if (sck_rise && !filt[`STP_IN_SEL]) begin
      // Older bits fall off the top: dummy bits leave first.
      next_shreg = {shreg[10:0], filt[`STP_IN_SDI]};
      if (bit_cnt < 4'(`STP_CMD_BITS)) begin
        next_bit_cnt = bit_cnt + 4'h1;
      end
    end
    // Short frames are spikes and leave the settings alone.
    if (sel_rise && bit_cnt >= 4'(`STP_CMD_BITS)) begin
      next_cmd = stp_pkg::stp_cmd_t'(shreg);
    end
  end

  // Command registers; after reset both coils are off.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      shreg   <= `STP_CMD_RST;
      bit_cnt <= 4'h0;
      cmd     <= stp_pkg::stp_cmd_t'(`STP_CMD_RST);
    end else begin
      shreg   <= next_shreg;
      bit_cnt <= next_bit_cnt;
      cmd     <= next_cmd;
    end
  end

  // Data out floats unless selected and enabled; the enable follows the
  // synchronised pins, so release lags the pins by a few cycles.
  assign link.sdo    = shreg[11];
  assign link.sdo_oe = ~filt[`STP_IN_SEL] & ~filt[`STP_IN_ENN];

  // ========================================================================
  // Chopper, one lane per phase: index 0 is phase A, 1 is phase B.
  logic [1:0]    pol;           // Commanded polarity.
  logic [1:0]    pol_q;         // Polarity seen by the chopper.
  logic [1:0]    pol_chg;       // Polarity changed this cycle.
  logic [1:0]    decay;         // Mixed decay selected.
  logic [1:0]    sense;         // Accepted comparator levels.
  logic [3:0]    cur [2];       // Current codes.
  logic [CW-1:0] chop [2];      // Position in the chopper period.
  logic [1:0]    on;            // Bridge driving current.
  logic [FW-1:0] fast [2];      // Fast decay cycles left.
  logic [1:0]    bridge [2];    // Registered bridge drive.
  logic [LW-1:0] ld_cnt;        // Cycles until the load reading settles.
  logic [1:0]    next_pol_q;
  logic [CW-1:0] next_chop [2];
  logic [1:0]    next_on;
  logic [FW-1:0] next_fast [2];
  logic [1:0]    next_bridge [2];
  logic [LW-1:0] next_ld_cnt;
  logic          next_load_valid;

  assign pol     = {cmd.phase_b_polarity, cmd.phase_a_polarity};
  assign decay   = {cmd.phase_b_mixed_decay, cmd.phase_a_mixed_decay};
  assign cur[0]  = cmd.phase_a_current;
  assign cur[1]  = cmd.phase_b_current;
  assign sense   = {filt[`STP_IN_SENSE_B], filt[`STP_IN_SENSE_A]};
  assign pol_chg = pol ^ pol_q;

  // Bridge drive for a current direction.
  function automatic logic [1:0] drive(input logic dir);
    drive = dir ? `STP_DRIVE_POS : `STP_DRIVE_NEG;
  endfunction : drive

  // Each period starts with the bridge on unless the code is zero or the comparator already
  // trips; a trip ends the on part, and mixed decay then reverses the
  // bridge for a while before slow decay.
  always_comb begin
    next_pol_q  = pol;
    next_on     = on;
    next_ld_cnt = ld_cnt;
    for (int p = 0; p < 2; p++) begin
      next_fast[p] = fast[p];
      // A new polarity starts a fresh period at once, well inside the
      // allowed delay after the frame ends.
      if (pol_chg[p] || chop[p] == CW'(CHOP_CYC - 1)) begin
        next_chop[p] = '0;
        next_on[p]   = (cur[p] != 4'h0) && !sense[p];
        next_fast[p] = '0;
      end else begin
        next_chop[p] = chop[p] + CW'(1);
        if (on[p] && sense[p]) begin
          next_on[p]   = 1'h0;
          next_fast[p] = decay[p] ? FW'(FAST_CYC) : '0;
        end else if (fast[p] != '0) begin
          next_fast[p] = fast[p] - FW'(1);
        end
      end
      // Code zero means no current at all, not a small one.
      if (filt[`STP_IN_ENN] || cur[p] == 4'h0) begin
        next_bridge[p] = `STP_DRIVE_OFF;
      end else if (on[p]) begin
        next_bridge[p] = drive(pol_q[p]);
      end else if (fast[p] != '0) begin
        next_bridge[p] = drive(~pol_q[p]);
      end else begin
        next_bridge[p] = `STP_DRIVE_OFF;
      end
    end
    // The load reading is flagged invalid after any polarity change.
    if (pol_chg != 2'h0) begin
      next_ld_cnt = LW'(LOAD_CYC);
    end else if (ld_cnt != '0) begin
      next_ld_cnt = ld_cnt - LW'(1);
    end
    next_load_valid = (next_ld_cnt == '0);
  end

  // Chopper registers; the load reading starts out valid.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      pol_q        <= 2'h0;
      on           <= 2'h0;
      ld_cnt       <= '0;
      load_valid_o <= 1'h1;
      for (int p = 0; p < 2; p++) begin
        chop[p]   <= '0;
        fast[p]   <= '0;
        bridge[p] <= `STP_DRIVE_OFF;
      end
    end else begin
      pol_q        <= next_pol_q;
      on           <= next_on;
      ld_cnt       <= next_ld_cnt;
      load_valid_o <= next_load_valid;
      for (int p = 0; p < 2; p++) begin
        chop[p]   <= next_chop[p];
        fast[p]   <= next_fast[p];
        bridge[p] <= next_bridge[p];
      end
    end
  end

  // ========================================================================
  // Outputs.
  assign bridge_a_outputs_o = bridge[0];
  assign bridge_b_outputs_o = bridge[1];
  assign phase_a_current_o  = cmd.phase_a_current;
  assign phase_b_current_o  = cmd.phase_b_current;
endmodule : stp_device

// ==== rtl/stp_host.sv ====
// Controller end: Avalon-MM registers driving the serial command link.
`timescale 1ns/1ps
`include "stp_cfg.svh"
module stp_host #(
  parameter int EN_CYC    = `STP_EN_SETUP_CYC,  // Wait after enable.
  parameter int HALF_CYC  = `STP_SCK_HALF_CYC,  // Serial clock half.
  parameter int GUARD_CYC = `STP_CS_GUARD_CYC,  // Clock quiet at select.
  parameter int LOAD_WAIT = `STP_LOAD_WAIT_CYC  // Load reading settle.
) (
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // Avalon-MM slave.
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Interrupt.
  output logic             irq_o,
  // Serial link.
  stp_link_if.host         link
);
  // ========================================================================
  // State.
  stp_pkg::stp_host_state_t state, next_state;
  logic        en, next_en;            // Bridges enabled.
  logic [3:0]  ext, next_ext;          // Extension current bits.
  logic [5:0]  len, next_len;          // Frame length in bits.
  logic [31:0] tx, next_tx;            // Outgoing bits, top first.
  logic [31:0] rx, next_rx;            // Incoming bits.
  logic [31:0] rxd, next_rxd;          // Last complete answer.
  logic [5:0]  left, next_left;        // Bits still to send.
  logic [15:0] tmr, next_tmr;          // Phase timer.
  logic [15:0] en_tmr, next_en_tmr;    // Time since enable.
  logic [15:0] ld_tmr, next_ld_tmr;    // Time left until the load reading settles.
  logic [1:0]  last_pol, next_last_pol;
  logic        sck, next_sck;
  logic        sel, next_sel;
  logic        sdi, next_sdi;
  logic [1:0]  irq_st, next_irq_st;    // Sticky events.
  logic [1:0]  irq_en, next_irq_en;    // Event enables.
  logic        rd_ack, next_rd_ack;
  logic [31:0] next_rdata;
  logic [2:0]  sdo_s;                  // Data-in synchroniser.
  logic        sdo_f, next_sdo_f;      // Accepted data-in level.
  logic        ready, fresh, start, wr_ok;
  logic [31:0] word;

  assign ready = (en_tmr == 16'(EN_CYC));
  assign fresh = (ld_tmr == 16'h0);
  // A frame may start once idle, after the enable settle time has passed or while the bridges are disabled.
  assign start = wr_ok && avs_address_i == `STP_REG_TXDATA;
  assign avs_waitrequest_o = (avs_read_i & ~rd_ack) |
    (avs_write_i && avs_address_i == `STP_REG_TXDATA &&
     !(state == stp_pkg::STP_H_IDLE && (ready || !en)));
  assign wr_ok = avs_write_i & ~avs_waitrequest_o;
  // Sixteen-bit frames carry the inverted extension bits on top.
  assign word = (len == 6'(`STP_FRAME_BITS)) ?
    {16'h0, ~ext, avs_writedata_i[11:0]} : avs_writedata_i;

  // Register access, enable timing and the frame sequencer.
  always_comb begin
    next_state = state;  next_en = en;  next_ext = ext;  next_len = len;
    next_tx = tx;  next_rx = rx;  next_rxd = rxd;  next_left = left;
    next_tmr = tmr;  next_sck = sck;  next_sel = sel;  next_sdi = sdi;
    // The load settle time counts from the end of the frame that changed
    // the polarity, so it is held full while the select is still low.
    if (ld_tmr == 16'h0) next_ld_tmr = ld_tmr;
    else if (!sel) next_ld_tmr = 16'(LOAD_WAIT);
    else next_ld_tmr = ld_tmr - 16'h1;
    next_last_pol = last_pol;
    next_irq_en = irq_en;
    next_irq_st = irq_st;
    next_rd_ack = avs_read_i & ~rd_ack;
    next_sdo_f = (sdo_s[1] == sdo_s[2]) ? sdo_s[2] : sdo_f;
    next_rdata = avs_readdata_o;
    if (avs_read_i && !rd_ack) begin
      unique case (avs_address_i)
        `STP_REG_CTRL:       next_rdata = {18'h0, len, ext, 3'h0, en};
        `STP_REG_RXDATA:     next_rdata = rxd;
        `STP_REG_STATUS:     next_rdata = {29'h0, fresh, ready,
                                 state != stp_pkg::STP_H_IDLE};
        `STP_REG_IRQ_STATUS: next_rdata = {30'h0, irq_st};
        `STP_REG_IRQ_ENABLE: next_rdata = {30'h0, irq_en};
        default:             next_rdata = 32'h0;
      endcase
    end
    if (wr_ok) begin
      unique case (avs_address_i)
        `STP_REG_CTRL: begin
          next_en  = avs_writedata_i[`STP_CTRL_EN_BIT];
          next_ext = avs_writedata_i[`STP_CTRL_EXT_MSB:`STP_CTRL_EXT_LSB];
          next_len = avs_writedata_i[`STP_CTRL_LEN_MSB:`STP_CTRL_LEN_LSB];
          if (next_len > 6'(`STP_WORD_BITS)) next_len = 6'(`STP_WORD_BITS);
          if (next_len == 6'h0) next_len = 6'h1;
        end
        `STP_REG_IRQ_ENABLE: next_irq_en = avs_writedata_i[1:0];
        default: ;
      endcase
    end
    // Settle timer restarts whenever the bridges are disabled.
    if (!en) next_en_tmr = 16'h0;
    else if (!ready) next_en_tmr = en_tmr + 16'h1;
    else next_en_tmr = en_tmr;
    unique case (state)
      stp_pkg::STP_H_IDLE: if (start) begin
        next_tx   = word << (6'(`STP_WORD_BITS) - len);
        next_sdi  = next_tx[31];
        next_sel  = 1'h0;
        next_left = len;
        next_rx   = 32'h0;
        next_tmr  = 16'(GUARD_CYC - 1);
        next_state = stp_pkg::STP_H_LEAD;
        // A polarity change makes the load reading stale for a while.
        next_last_pol = {word[`STP_POL_A_BIT], word[`STP_POL_B_BIT]};
        if (next_last_pol != last_pol) next_ld_tmr = 16'(LOAD_WAIT);
      end
      stp_pkg::STP_H_LEAD: if (tmr == 16'h0) begin
        next_tmr = 16'(HALF_CYC - 1);
        next_state = stp_pkg::STP_H_LOW;
      end else next_tmr = tmr - 16'h1;
      stp_pkg::STP_H_LOW: if (tmr == 16'h0) begin
        next_sck = 1'h1;
        next_tmr = 16'(HALF_CYC - 1);
        next_state = stp_pkg::STP_H_HIGH;
      end else next_tmr = tmr - 16'h1;
      stp_pkg::STP_H_HIGH: if (tmr == 16'h0) begin
        // Data out is taken at the end of the high phase: the answer needs
        // both synchronisers' time to come back, so the rise is too early.
        next_rx   = {rx[30:0], sdo_f};
        next_sck  = 1'h0;
        next_left = left - 6'h1;
        if (left == 6'h1) begin
          next_tmr = 16'(GUARD_CYC - 1);
          next_state = stp_pkg::STP_H_TRAIL;
        end else begin
          next_tx  = {tx[30:0], 1'h0};
          next_sdi = tx[30];
          next_tmr = 16'(HALF_CYC - 1);
          next_state = stp_pkg::STP_H_LOW;
        end
      end else next_tmr = tmr - 16'h1;
      stp_pkg::STP_H_TRAIL: if (tmr == 16'h0) begin
        next_sel = 1'h1;
        next_rxd = rx;
        next_irq_st[`STP_IRQ_DONE] = 1'h1;
        next_tmr = 16'(HALF_CYC - 1);
        next_state = stp_pkg::STP_H_GAP;
      end else next_tmr = tmr - 16'h1;
      stp_pkg::STP_H_GAP: if (tmr == 16'h0) begin
        next_state = stp_pkg::STP_H_IDLE;
      end else next_tmr = tmr - 16'h1;
    endcase
    // Clearing keeps a ready event raised in the same cycle, but a done event only if its bit was not already set.
    if (wr_ok && avs_address_i == `STP_REG_IRQ_CLEAR)
      next_irq_st = next_irq_st & ~avs_writedata_i[1:0] |
                    (next_irq_st & ~irq_st);
    if (en && next_en_tmr == 16'(EN_CYC) && !ready)
      next_irq_st[`STP_IRQ_READY] = 1'h1;
  end

  // All registers; the link idles deselected with bridges disabled.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      state <= stp_pkg::STP_H_IDLE;  en <= 1'h0;  ext <= 4'h0;
      len <= `STP_CTRL_LEN_RST;  tx <= 32'h0;  rx <= 32'h0;
      rxd <= 32'h0;  left <= 6'h0;  tmr <= 16'h0;  en_tmr <= 16'h0;
      ld_tmr <= 16'h0;  last_pol <= 2'h0;  sck <= 1'h0;  sel <= 1'h1;
      sdi <= 1'h0;  irq_st <= 2'h0;  irq_en <= 2'h0;  rd_ack <= 1'h0;
      avs_readdata_o <= 32'h0;  sdo_s <= 3'h7;  sdo_f <= 1'h1;
    end else begin
      state <= next_state;  en <= next_en;  ext <= next_ext;
      len <= next_len;  tx <= next_tx;  rx <= next_rx;  rxd <= next_rxd;
      left <= next_left;  tmr <= next_tmr;  en_tmr <= next_en_tmr;
      ld_tmr <= next_ld_tmr;  last_pol <= next_last_pol;  sck <= next_sck;
      sel <= next_sel;  sdi <= next_sdi;  irq_st <= next_irq_st;
      irq_en <= next_irq_en;  rd_ack <= next_rd_ack;
      avs_readdata_o <= next_rdata;
      sdo_s <= {sdo_s[1:0], link.sdo_line};  sdo_f <= next_sdo_f;
    end
  end

  // ========================================================================
  // Outputs.
  assign irq_o                  = |(irq_st & irq_en);
  assign link.sck               = sck;
  assign link.select_low        = sel;
  assign link.sdi               = sdi;
  assign link.driver_enable_low = ~en;
endmodule : stp_host

// ==== test/stp_link_chk.sv ====
// Checker of the serial link between the controller and the driver.
`timescale 1ns/1ps
module stp_link_chk #(parameter int EN_CYC = 30) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic sck,
  input wire logic select_low,
  input wire logic sdi,
  input wire logic driver_enable_low,
  input wire logic sdo,
  input wire logic sdo_oe
);
  int en_cnt;  // Cycles since the bridges were enabled, saturating.
  // ========================================================================
  // The count restarts whenever the enable is dropped.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || driver_enable_low) en_cnt <= 0;
    else if (en_cnt < EN_CYC) en_cnt <= en_cnt + 1;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_float_unsel: assert property (select_low [*6] |-> !sdo_oe)
    else $error("data out driven while unselected");
  a_float_off: assert property (driver_enable_low [*6] |-> !sdo_oe)
    else $error("data out driven while disabled");
  a_sck_idle: assert property (select_low |-> !sck)
    else $error("serial clock runs outside a frame");
  a_sck_lead: assert property ($fell(select_low) |-> !sck ##1 !sck)
    else $error("serial clock moves right after select");
  a_sck_trail: assert property ($rose(select_low) |->
    !$past(sck, 1) && !$past(sck, 2))
    else $error("serial clock moves right before release");
  a_sck_high: assert property ($rose(sck) |-> sck [*5] ##1 !sck)
    else $error("serial clock high width wrong");
  a_sdi_hold: assert property (sck && $past(sck) |-> $stable(sdi))
    else $error("data changed while clock high");
  // Clocking a disabled driver is allowed; only enabled frames must wait.
  a_en_setup: assert property ($rose(sck) && !driver_enable_low |->
    en_cnt >= EN_CYC)
    else $error("clock too soon after enable");
  c_frame: cover property ($rose(select_low));
  c_drive: cover property (sdo_oe && sdo);
  c_clock: cover property ($rose(sck));
endmodule : stp_link_chk

// ==== test/tb_stepper_spi_command_port.sv ====
// Bench of controller and driver joined across the serial link.
`timescale 1ns/1ps
module tb_stepper_spi_command_port;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, sa = 0, sb = 0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [11:0] diag = 12'h9c3;  // Word the driver returns.
  logic wt, irq, lv;
  logic [1:0] ba, bb;
  logic [3:0] ca, cb;
  int n_errors = 0, total_checks = 0;
  stp_link_if link ();
  stp_host #(.EN_CYC(30), .LOAD_WAIT(60)) i_stp_host (.core_clk_i(clk),
    .reset_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .irq_o(irq), .link(link));
  stp_device #(.CHOP_CYC(40), .FAST_CYC(10), .LOAD_CYC(20)) i_stp_device (
    .core_clk_i(clk), .reset_n_i(rst_n), .link(link),
    .phase_a_sense_input_i(sa), .phase_b_sense_input_i(sb), .diag_i(diag),
    .bridge_a_outputs_o(ba), .bridge_b_outputs_o(bb),
    .phase_a_current_o(ca), .phase_b_current_o(cb), .load_valid_o(lv));
  stp_link_chk i_chk (.core_clk_i(clk), .reset_n_i(rst_n),
    .sck(link.sck), .select_low(link.select_low), .sdi(link.sdi),
    .driver_enable_low(link.driver_enable_low), .sdo(link.sdo),
    .sdo_oe(link.sdo_oe));
  initial forever #12.5 clk = ~clk;
  // ========================================================================
  // Compare, count and report a mismatch at once.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %0t seen %h wanted %h", $time, s, e);
    end
  endtask : chk
  task automatic report_and_stop;
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // Avalon cycle: held until waitrequest is seen low at an edge, then
  // released with one idle edge, so no strobe is set twice at once.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    adr <= a; wd <= d; wr <= w; rd <= !w;
    do @(posedge clk); while (wt !== 1'b0);
    q = rdat; wr <= 0; rd <= 0;
    @(posedge clk);
  endtask : bus
  // One frame of n bits, bridges enabled or not; waits until idle.
  task automatic send(input logic [5:0] n, input logic [15:0] w,
                      input logic e);
    bus(1, 5'h00, {18'h0, n, 7'h00, e}); bus(1, 5'h04, {16'h0, w});
    do bus(0, 5'h0c, 0); while (q[0] !== 1'b0);
    repeat (12) @(posedge clk);
  endtask : send
  task automatic t_regs;
    bus(0, 5'h00, 0); chk(q, 32'h1000); bus(0, 5'h1c, 0); chk(q, 0);
  endtask : t_regs
  task automatic t_cmd;
    bus(1, 5'h18, 1); send(16, 16'hf56a, 1); chk(irq, 1);
    repeat (40) @(posedge clk);  // Phase B starts at its next period.
    chk({ca, cb, ba, bb}, {8'ha5, 2'h2, 2'h1});
    bus(0, 5'h08, 0); chk(q, 32'h9c3f);
    bus(0, 5'h10, 0); chk(q[0], 1); bus(1, 5'h14, 1); chk(irq, 0);
    bus(1, 5'h18, 0); send(8, 16'h0000, 0);
    chk(ca, 4'ha); chk(irq, 0);
    bus(0, 5'h08, 0); chk(q, 32'hff);
  endtask : t_cmd
  task automatic t_short12;
    diag <= 12'h3c5;  // Top bit low, so a lost first bit shows.
    send(12, 16'h006a, 1); chk(ba, 2'h0); chk(cb, 4'h5);
    bus(0, 5'h08, 0); chk(q[11:0], 12'h3c5);
  endtask : t_short12
  task automatic t_trip;
    send(16, 16'h056a, 1); sa <= 1; send(16, 16'h052a, 1);
    bus(0, 5'h0c, 0); chk(q[2], 0);
    repeat (41) begin
      @(posedge clk); chk(ba, 2'h0);
    end
    chk(bb, 2'h1); sa <= 0; sb <= 1; repeat (60) @(posedge clk);
    chk(ba, 2'h1);
    chk(bb, 2'h0);
    chk(lv, 1);
    bus(0, 5'h0c, 0); chk(q[2], 1);
  endtask : t_trip
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1; @(posedge clk);
    t_regs; t_cmd; t_short12; t_trip; report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++; report_and_stop;
  end
endmodule : tb_stepper_spi_command_port
